// ### hdl/sarseq_pkg.sv
// Package for the converter sequencer: register map, reset values, field positions,
// state codes and cycle counts.
// Assumes a single 40 MHz reference clock, used as the converter subsystem clock.
package sarseq_pkg;

   // Byte-wide register map.
   localparam logic [7:0] ADDR_TRACK_PWR  = 8'hBA;
   localparam logic [7:0] ADDR_CHAN_SEL   = 8'hBB;
   localparam logic [7:0] ADDR_CONFIG     = 8'hBC;
   localparam logic [7:0] ADDR_RESULT_LO  = 8'hBD;
   localparam logic [7:0] ADDR_RESULT_HI  = 8'hBE;
   localparam logic [7:0] ADDR_CONTROL    = 8'hE8;

   // Values after reset.
   localparam logic [7:0] RST_TRACK_PWR   = 8'hFF;
   localparam logic [7:0] RST_CHAN_SEL    = 8'h1F;
   localparam logic [7:0] RST_CONFIG      = 8'hF8;
   localparam logic [7:0] RST_RESULT      = 8'h00;
   localparam logic [7:0] RST_CONTROL     = 8'h00;

   // Control register bit positions.
   localparam int CTL_ENABLE = 7;
   localparam int CTL_BURST  = 6;
   localparam int CTL_DONE   = 5;
   localparam int CTL_BUSY   = 4;
   localparam int CTL_WINDOW = 3;
   localparam int CTL_LJUST  = 2;

   // Start source codes.
   localparam logic [1:0] SRC_SOFTWARE = 2'h0;
   localparam logic [1:0] SRC_EXT_PIN  = 2'h2;

   // Tracking mode codes.
   localparam logic [1:0] TRK_PRE  = 2'h2;
   localparam logic [1:0] TRK_DUAL = 2'h3;

   // Sequencing cycle counts, in subsystem clock and conversion clock periods.
   localparam logic [9:0] CONV_SAR_CLKS   = 10'h00D;
   localparam logic [9:0] CONVERTER_SUBSYSTEM_CLOCK_OVERHEAD   = 10'h002;
   localparam int         CLK_MHZ         = 40;
   localparam int         PWRUP_STEP_NS   = 200;
   localparam logic [9:0] PWRUP_STEP_CYC  = 10'((PWRUP_STEP_NS * CLK_MHZ + 999) / 1000);

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PWRUP = 2'b01,
      ST_TRACK = 2'b10,
      ST_CONV  = 2'b11
   } sarseq_state_t;

   // One register bus request.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sarseq_req_t;

endpackage : sarseq_pkg

// ### hdl/sarseq_top.sv
// Converter sequencer: start selection, power sequencing, tracking, accumulation and
// result formatting, plus the byte registers reached by software.
// Assumes the analog core presents a stable 12-bit code on sample_code at conversion end.
// Function
// - Justify clear puts result right-aligned in the data byte pair.
// - Justify set shifts 12-bit result to the top, low four bits zero.
// - Repeat of one gives 12-bit code, refreshed after every conversion.
// - Larger repeat sums results, written only after the last conversion.
// - Sums are 14, 15 or 16 bits wide for 4, 8, 16 samples.
// - Data bits not occupied by the result read as zero.
// - Configuration bits 2..1 select 1, 4, 8 or 16 accumulated conversions.
// - Right-justified high byte holds top 4, 6, 7 or 8 result bits.
// - Subsystem clock is system clock, or burst oscillator when burst is on.
// - Enable clear means shutdown; set means active and accepting starts.
// - Burst with enable clear powers up, runs the series, powers down.
// - Start source field picks busy write, pin rising edge or timer overflow.
// - Busy is high during conversion; done is set only when the last conversion of the series ends.
// - Burst start runs the whole series; otherwise one start per conversion.
// - A conversion lasts 13 conversion clocks plus 2 subsystem clocks.
`timescale 1ns/100ps
module sarseq_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire sarseq_pkg::sarseq_req_t bus_req,
   output logic [7:0]                bus_rdata,
   input  wire logic                 external_convert_start,
   input  wire logic                 timer_overflow,
   input  wire logic [11:0]          sample_code,
   output logic                      burst_clock_sel,
   output logic                      converter_powered,
   output logic                      track_switch,
   output logic                      converting,
   output logic                      attenuation_program,
   output logic [4:0]                input_channel_sel
);
   import sarseq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Registers and working state.
   logic [7:0]    track_pwr_r, chan_sel_r, config_r, res_lo_r, res_hi_r, control_r, ctl_now;
   sarseq_state_t state_r;
   logic [9:0]    cnt_r;
   logic [4:0]    conv_num_r;
   logic [15:0]   acc_r;
   logic [1:0]    pin_sync_r;
   logic          pin_prev_r;
   logic          busy_r;
   logic          series_end;
   logic          start_evt;
   logic [4:0]    reps;
   logic [9:0]    sar_div;
   logic [9:0]    track_cyc;
   logic [9:0]    conv_cyc;
   logic [9:0]    pwrup_cyc;
   logic [15:0]   sum_nxt;
   logic [15:0]   word_nxt;
   logic          wr_ctl;

   // Field decode of the configuration and tracking registers.
   assign sar_div   = {5'h00, config_r[7:3]} + 10'h001;
   assign conv_cyc  = 10'(CONV_SAR_CLKS * sar_div) + CONVERTER_SUBSYSTEM_CLOCK_OVERHEAD;
   assign track_cyc = 10'((10'h002 << track_pwr_r[1:0]) * sar_div) + CONVERTER_SUBSYSTEM_CLOCK_OVERHEAD;
   assign pwrup_cyc = 10'({6'h00, track_pwr_r[7:4]} + 10'h001) * PWRUP_STEP_CYC;
   assign reps      = (config_r[2:1] == 2'h0) ? 5'd1 : 5'(5'd2 << config_r[2:1]);
   assign wr_ctl    = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
   assign ctl_now   = wr_ctl ? bus_req.wdata : control_r;  // A control write counts at once.

   ////////////////////////////////////////////////////////////////////////////////////////
   // External start pin: two-flop synchroniser, then rising edge detection.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_sync_r <= 2'h0;
         pin_prev_r <= 1'b0;
      end else begin
         pin_sync_r <= {pin_sync_r[0], external_convert_start};
         pin_prev_r <= pin_sync_r[1];
      end
   end

   // Start event from the selected source; only taken while idle and not shut down.
   always_comb begin
      case (ctl_now[1:0])
         SRC_SOFTWARE: start_evt = wr_ctl && bus_req.wdata[CTL_BUSY];
         SRC_EXT_PIN:  start_evt = pin_sync_r[1] && !pin_prev_r;
         default:      start_evt = timer_overflow;
      endcase
      start_evt = start_evt && (state_r == ST_IDLE)
                  && (ctl_now[CTL_ENABLE] || ctl_now[CTL_BURST]);
   end

   // Accumulated and formatted result words.
   assign sum_nxt    = acc_r + {4'h0, sample_code};
   assign series_end = (state_r == ST_CONV) && (cnt_r == 10'h001)
                       && (conv_num_r + 5'd1 == reps);
   always_comb begin
      if (control_r[CTL_LJUST] && config_r[2:1] == 2'h0) begin
         word_nxt = {sample_code, 4'h0};
      end else begin
         word_nxt = sum_nxt;                  // Upper bits stay zero.
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer: power-up, tracking and conversion phases.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         cnt_r      <= 10'h000;
         conv_num_r <= 5'd0;
         acc_r      <= 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_evt) begin
                  if (ctl_now[CTL_BURST] && !ctl_now[CTL_ENABLE]) begin
                     state_r <= ST_PWRUP;
                     cnt_r   <= pwrup_cyc;
                  end else if (track_pwr_r[3:2] == TRK_PRE && !ctl_now[CTL_BURST]) begin
                     state_r <= ST_CONV;
                     cnt_r   <= conv_cyc;
                  end else begin
                     state_r <= ST_TRACK;
                     cnt_r   <= track_cyc;
                  end
               end
            end
            ST_PWRUP: begin
               cnt_r <= cnt_r - 10'h001;
               if (cnt_r == 10'h001) begin
                  state_r <= ST_TRACK;
                  cnt_r   <= track_cyc;
               end
            end
            ST_TRACK: begin
               cnt_r <= cnt_r - 10'h001;
               if (cnt_r == 10'h001) begin
                  state_r <= ST_CONV;
                  cnt_r   <= conv_cyc;
               end
            end
            ST_CONV: begin
               cnt_r <= cnt_r - 10'h001;
               if (cnt_r == 10'h001) begin
                  if (series_end) begin
                     conv_num_r <= 5'd0;
                     acc_r      <= 16'h0000;
                  end else begin
                     conv_num_r <= conv_num_r + 5'd1;
                     acc_r      <= sum_nxt;
                  end
                  if (control_r[CTL_BURST] && !series_end) begin
                     state_r <= ST_TRACK;
                     cnt_r   <= track_cyc;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Busy is high from the start until the conversion ends, or in burst until the last conversion of the series ends.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else if (start_evt) begin
         busy_r <= 1'b1;
      end else if (state_r == ST_CONV && cnt_r == 10'h001
                   && (series_end || !control_r[CTL_BURST])) begin
         busy_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Control register; the done flag set by the sequencer wins over a software clear.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         control_r <= RST_CONTROL;
      end else begin
         if (wr_ctl) begin
            control_r <= bus_req.wdata;
         end
         if (series_end) begin
            control_r[CTL_DONE] <= 1'b1;
         end
      end
   end

   // Result bytes: a finished series overrides a software write in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         res_hi_r <= RST_RESULT;
         res_lo_r <= RST_RESULT;
      end else if (series_end) begin
         res_hi_r <= word_nxt[15:8];
         res_lo_r <= word_nxt[7:0];
      end else if (bus_req.wr) begin
         if (bus_req.addr == ADDR_RESULT_HI) begin
            res_hi_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_RESULT_LO) begin
            res_lo_r <= bus_req.wdata;
         end
      end
   end

   // Configuration, tracking and channel registers.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         track_pwr_r <= RST_TRACK_PWR;
         chan_sel_r  <= RST_CHAN_SEL;
         config_r    <= RST_CONFIG;
      end else if (bus_req.wr) begin
         if (bus_req.addr == ADDR_TRACK_PWR) begin
            track_pwr_r <= bus_req.wdata;
         end else if (bus_req.addr == ADDR_CHAN_SEL) begin
            chan_sel_r  <= {3'h0, bus_req.wdata[4:0]};
         end else if (bus_req.addr == ADDR_CONFIG) begin
            config_r    <= bus_req.wdata;
         end
      end
   end

   // Read data, registered one cycle after the read strobe; unmapped reads return zero.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else if (!bus_req.rd) begin
         bus_rdata <= 8'h00;
      end else if (bus_req.addr == ADDR_TRACK_PWR) begin
         bus_rdata <= track_pwr_r;
      end else if (bus_req.addr == ADDR_CHAN_SEL) begin
         bus_rdata <= chan_sel_r;
      end else if (bus_req.addr == ADDR_CONFIG) begin
         bus_rdata <= config_r;
      end else if (bus_req.addr == ADDR_RESULT_LO) begin
         bus_rdata <= res_lo_r;
      end else if (bus_req.addr == ADDR_RESULT_HI) begin
         bus_rdata <= res_hi_r;
      end else if (bus_req.addr == ADDR_CONTROL) begin
         bus_rdata <= {control_r[7:5], busy_r, control_r[3:0]};
      end else begin
         bus_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Analog controls. Power-up idles in post-tracking and tracks in dual-tracking.
   assign burst_clock_sel     = control_r[CTL_BURST];
   assign converter_powered   = control_r[CTL_ENABLE] || (state_r != ST_IDLE);
   assign converting          = (state_r == ST_CONV);
   assign attenuation_program = config_r[0];
   assign input_channel_sel   = chan_sel_r[4:0];
   assign track_switch = (state_r == ST_TRACK)
                         || (state_r == ST_PWRUP && track_pwr_r[3:2] == TRK_DUAL)
                         || (state_r == ST_IDLE && control_r[CTL_ENABLE]
                             && track_pwr_r[3] == 1'b1);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and result formatting.
   sequence s_conv_last;
      state_r == ST_CONV && cnt_r == 10'h001;
   endsequence
   sequence s_start_idle;
      start_evt && state_r == ST_IDLE;
   endsequence

   AST_DONE_ON_END: assert property (@(posedge ref_clk) disable iff (rst)
      series_end |=> control_r[CTL_DONE] && !busy_r)
      else $error("Done flag or busy wrong after a series.");
   AST_LJUST_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
      series_end && control_r[CTL_LJUST] && config_r[2:1] == 2'h0 |=> res_lo_r[3:0] == 4'h0)
      else $error("Left-justified low nibble not zero.");
   AST_RJUST_ONE: assert property (@(posedge ref_clk) disable iff (rst)
      series_end && !control_r[CTL_LJUST] && config_r[2:1] == 2'h0
      |=> {res_hi_r, res_lo_r} == {4'h0, $past(sample_code)})
      else $error("Right-justified single result wrong.");
   AST_SUM_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
      series_end && config_r[2:1] == 2'h1 && !control_r[CTL_LJUST] |=> res_hi_r[7:6] == 2'h0)
      else $error("Four-sample sum exceeds 14 bits.");
   AST_NO_START_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      !ctl_now[CTL_ENABLE] && !ctl_now[CTL_BURST] && state_r == ST_IDLE |=> state_r == ST_IDLE)
      else $error("Start accepted while shut down.");
   AST_BUSY_ON_START: assert property (@(posedge ref_clk) disable iff (rst)
      s_start_idle |=> busy_r && state_r != ST_IDLE)
      else $error("Start not taken.");
   AST_CONV_LEN: assert property (@(posedge ref_clk) disable iff (rst)
      state_r == ST_TRACK && cnt_r == 10'h001 ##1 state_r == ST_CONV |-> cnt_r == conv_cyc)
      else $error("Conversion length wrong.");
   AST_BURST_PWRUP: assert property (@(posedge ref_clk) disable iff (rst)
      s_start_idle ##0 (ctl_now[CTL_BURST] && !ctl_now[CTL_ENABLE]) |=> state_r == ST_PWRUP)
      else $error("Burst start skipped power-up.");
   AST_SINGLE_STEP: assert property (@(posedge ref_clk) disable iff (rst)
      s_conv_last ##0 !control_r[CTL_BURST] |=> state_r == ST_IDLE)
      else $error("Normal mode ran on without a start.");
endmodule : sarseq_top

// ### test/tb.sv
// Self-checking bench for the converter sequencer, driving its byte register bus.
// Assumes the sequencer package and top module are compiled first; one 40 MHz clock.
`timescale 1ns/100ps
module tb;
   import sarseq_pkg::*;
   logic                ref_clk, rst, external_convert_start, timer_overflow;
   logic [11:0]         sample_code;
   sarseq_req_t         bus_req;
   logic [7:0]          bus_rdata, d;
   logic                burst_clock_sel, converter_powered, track_switch, converting;
   logic                attenuation_program;
   logic [4:0]          input_channel_sel;
   logic [15:0]         r, prev, expv;
   int                  errors, comparisons, conv_cnt, trk_cnt, n;

   sarseq_top i_sarseq_top (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .external_convert_start(external_convert_start),
      .timer_overflow(timer_overflow), .sample_code(sample_code),
      .burst_clock_sel(burst_clock_sel), .converter_powered(converter_powered),
      .track_switch(track_switch), .converting(converting),
      .attenuation_program(attenuation_program), .input_channel_sel(input_channel_sel));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock generator, 25 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Counts cycles spent converting and tracking, for the timing checks.
   always @(posedge ref_clk) begin
      if (converting === 1'b1) conv_cnt++;
      if (track_switch === 1'b1) trk_cnt++;
   end

   // Watchdog that cuts a hung run short.
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   task tick;
      @(posedge ref_clk);
      #1;
   endtask : tick

   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // A write strobe lasts one edge; an idle edge follows so strobes never collide.
   task wr(input logic [7:0] a, input logic [7:0] v);
      bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      tick();
      bus_req.wr = 1'b0;
      tick();
   endtask : wr

   task rd(input logic [7:0] a, output logic [7:0] v);
      bus_req.addr = a;
      bus_req.rd   = 1'b1;
      tick();
      bus_req.rd   = 1'b0;
      v            = bus_rdata;
      tick();
   endtask : rd

   // Polls one control bit until it reaches the wanted level, bounded.
   task wait_flag(input int b, input logic val);
      for (n = 0; n < 3000; n++) begin
         rd(ADDR_CONTROL, d);
         if (d[b] === val) break;
      end
      chk(16'(d[b]), 16'(val));
   endtask : wait_flag

   task res(output logic [15:0] v);
      logic [7:0] h;
      logic [7:0] l;
      rd(ADDR_RESULT_HI, h);
      rd(ADDR_RESULT_LO, l);
      v = {h, l};
   endtask : res

   task run(input logic [7:0] ctl, input logic [11:0] s);
      sample_code = s;
      conv_cnt    = 0;
      trk_cnt     = 0;
      wr(ADDR_CONTROL, ctl);
      wait_flag(CTL_DONE, 1'b1);
      rd(ADDR_CONTROL, d);
      chk(16'(d[CTL_BUSY]), 16'h0000);
      res(r);
   endtask : run

   task end_sim;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial begin
      logic [7:0] ra [6];
      logic [7:0] rv [6];
      ra = '{ADDR_TRACK_PWR, ADDR_CHAN_SEL, ADDR_CONFIG, ADDR_RESULT_HI, ADDR_CONTROL, 8'hC0};
      rv = '{8'hFF, 8'h1F, 8'hF8, 8'h00, 8'h00, 8'h00};
      rst = 1'b1;
      bus_req = '0;
      external_convert_start = 1'b0;
      timer_overflow = 1'b0;
      sample_code = 12'hFFF;
      errors = 0;
      comparisons = 0;
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
      // Reset values, channel field width, unmapped place and configuration outputs.
      for (int i = 0; i < 6; i++) begin
         rd(ra[i], d);
         chk(16'(d), 16'(rv[i]));
      end
      chk(16'(input_channel_sel), 16'h001F);
      wr(ADDR_CHAN_SEL, 8'hE5);
      rd(ADDR_CHAN_SEL, d);
      chk(16'(d), 16'h0005);
      chk(16'(input_channel_sel), 16'h0005);
      wr(8'hC0, 8'h5A);
      rd(8'hC0, d);
      chk(16'(d), 16'h0000);
      wr(ADDR_CONFIG, 8'h09);
      chk(16'(attenuation_program), 16'h0001);
      $display("test registers finished");
      // Single conversions, divider 2: justification, track and conversion lengths.
      wr(ADDR_TRACK_PWR, 8'h04);
      run(8'h90, 12'hFFF);
      chk(r, 16'h0FFF);
      chk(16'(conv_cnt), 16'd28);
      chk(16'(trk_cnt), 16'd6);
      run(8'h94, 12'h7FF);
      chk(r, 16'h7FF0);
      wr(ADDR_TRACK_PWR, 8'h05);
      run(8'h94, 12'h800);
      chk(r, 16'h8000);
      chk(16'(trk_cnt), 16'd10);
      wr(ADDR_TRACK_PWR, 8'h08);
      run(8'h90, 12'h123);
      chk(r, 16'h0123);
      chk(16'(track_switch), 16'h0001);
      chk(16'(conv_cnt), 16'd28);
      $display("test single finished");
      // Shutdown ignores starts; a busy write is refused under the pin source.
      conv_cnt = 0;
      wr(ADDR_CONTROL, 8'h10);
      repeat (30) tick();
      chk(16'(conv_cnt), 16'd0);
      chk(16'(converter_powered), 16'h0000);
      wr(ADDR_CONTROL, 8'h92);
      repeat (40) tick();
      chk(16'(conv_cnt), 16'd0);
      // Pin rising edge and timer overflow starts.
      wr(ADDR_TRACK_PWR, 8'h04);
      external_convert_start = 1'b1;
      sample_code = 12'hABC;
      wait_flag(CTL_DONE, 1'b1);
      external_convert_start = 1'b0;
      res(r);
      chk(r, 16'h0ABC);
      for (int s = 1; s < 4; s += 2) begin
         wr(ADDR_CONTROL, 8'h80 | 8'(s));
         sample_code = 12'(12'h100 * s);
         timer_overflow = 1'b1;
         tick();
         timer_overflow = 1'b0;
         wait_flag(CTL_DONE, 1'b1);
         res(r);
         chk(r, 16'(sample_code));
      end
      prev = r;
      $display("test starts finished");
      // Normal-mode accumulation, right-justified, one start per conversion.
      sample_code = 12'hFFF;
      for (int c = 1; c < 4; c++) begin
         wr(ADDR_CONFIG, 8'(c << 1));
         expv = 16'(16'h0FFF * (2 << c));
         for (int k = 0; k < (2 << c); k++) begin
            wr(ADDR_CONTROL, 8'h90);
            if (k < (2 << c) - 1) begin
               wait_flag(CTL_BUSY, 1'b0);
            end else begin
               wait_flag(CTL_DONE, 1'b1);
            end
            if (k == 0) begin
               rd(ADDR_CONTROL, d);
               chk(16'(d[CTL_DONE]), 16'h0000);
               res(r);
               chk(r, prev);
            end
         end
         res(r);
         chk(r, expv);
         prev = expv;
      end
      $display("test accumulate finished");
      // Burst with enable clear: power up, four pairs, power down.
      wr(ADDR_CONFIG, 8'h02);
      sample_code = 12'h123;
      conv_cnt = 0;
      trk_cnt = 0;
      wr(ADDR_CONTROL, 8'h50);
      chk(16'(converter_powered), 16'h0001);
      chk(16'(burst_clock_sel), 16'h0001);
      wait_flag(CTL_DONE, 1'b1);
      res(r);
      chk(r, 16'h048C);
      chk(16'(conv_cnt), 16'd60);
      chk(16'(trk_cnt), 16'd16);
      chk(16'(converter_powered), 16'h0000);
      // Dual tracking in burst: the switch is also closed through power-up.
      wr(ADDR_TRACK_PWR, 8'h0C);
      trk_cnt = 0;
      wr(ADDR_CONTROL, 8'h50);
      wait_flag(CTL_DONE, 1'b1);
      chk(16'(trk_cnt), 16'd24);
      res(r);
      chk(r, 16'h048C);
      $display("test burst finished");
      end_sim();
   end
endmodule : tb
